// *** logic/sctrc_bitclk.sv ***
/*
  Bit clock source: an internal divider of the system clock or the
  rising edge of an already synchronised modem clock.
  Assumes div is at least 2 and stable while a word is in flight.
*/
`timescale 1ns/1ps
`default_nettype none
module sctrc_bitclk (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // Control
  input  wire logic        ext_sel,
  input  wire logic [15:0] div,
  input  wire logic        restart,
  input  wire logic        mclk_sync,
  // Bit tick, one cycle
  output logic             tick
);
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic        mclk_prev_reg;
  wire         int_wrap = (cnt_reg >= div - 16'h1);

  // Restart realigns the divider to a detected start bit
  assign cnt_next = (restart || int_wrap) ? 16'h0 : cnt_reg + 16'h1;
  assign tick     = ext_sel ? (mclk_sync && !mclk_prev_reg)
                            : (int_wrap && !restart);

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_reg       <= 16'h0;
      mclk_prev_reg <= 1'b1;
    end
    else
    begin
      cnt_reg       <= cnt_next;
      mclk_prev_reg <= mclk_sync;
    end
  end
endmodule : sctrc_bitclk
`default_nettype wire

// *** logic/sctrc_coupler.sv ***
/*
  Serial coupler between the processor word port and a modem:
  one transmit path, one receive path, error flag and interrupts.
  Assumes a register port master that never issues read and write
  together, and modem pins asynchronous to clock.
*/
`timescale 1ns/1ps
`default_nettype none
module sctrc_coupler #(
  parameter int ABORT_CYCLES = sctrc_pkg::ABORT_CYC
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // Register port
  input  wire logic [3:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr_stb,
  input  wire logic        rd_stb,
  output logic      [31:0] rdata,
  // Processor events
  input  wire logic        clear_alarm,
  output logic             out_irq,
  output logic             in_irq,
  // Modem pins
  input  wire logic        serial_line_in,
  input  wire logic        modem_clear_send_in,
  input  wire logic        modem_set_ready_in,
  input  wire logic        modem_carrier_in,
  input  wire logic        modem_clock_in,
  output logic             serial_line_out,
  output logic             modem_request_send_out
);
  localparam int AW = $clog2(ABORT_CYCLES + 1);
  localparam int FW = sctrc_pkg::FRAME_W;

  // Mask of the low n data bits
  function automatic logic [23:0] wmask(input logic [4:0] n);
    wmask = 24'hffffff >> (5'd24 - n);
  endfunction : wmask

  // Shift right and drop a received bit into cell pos
  function automatic logic [FW-1:0] rx_ins(input logic [FW-1:0] sh,
                                           input logic b, input logic [4:0] pos);
    logic [FW-1:0] t;
    t = {1'b1, sh[FW-1:1]};
    rx_ins = (t & ~(28'h1 << pos)) | ({27'h0, b} << pos);
  endfunction : rx_ins

  // Synchronised pins
  logic [4:0] pins_sync;
  logic line_s, cts_s, dsr_s, dcd_s, mclk_s;
  sctrc_sync #(.W(5)) u_sync (
    .clock    (clock),
    .rst_n    (rst_n),
    .pin_in   ({serial_line_in, modem_clear_send_in, modem_set_ready_in,
                modem_carrier_in, modem_clock_in}),
    .sync_out (pins_sync)
  );
  assign {line_s, cts_s, dsr_s, dcd_s, mclk_s} = pins_sync;

  // State registers
  logic [31:0]   cfg_reg;
  logic          out_b_reg;
  logic [23:0]   acc_reg;
  logic [FW-1:0] tx_sh_reg;
  logic [5:0]    tx_cnt_reg;
  logic          parity_gen_check_flag;
  logic          transmitting_flag;
  logic          bit_counter_overflow_flag;
  logic          request_send_flag;
  logic          out_pend_reg;
  logic          line_out_reg;
  logic [AW-1:0] abort_cnt_reg;
  logic          abort_run_reg;
  logic          line_prev_reg;
  logic          first_bit_flag;
  logic [15:0]   half_cnt_reg;
  logic          busy_receiving_flag;
  logic          enable_receive_flag;
  logic [FW-1:0] rx_sh_reg;
  logic          post_receive_delay_flag;
  logic          in_avail_reg;
  logic          line_error_flag;
  logic          out_irq_reg;
  logic          in_irq_reg;
  logic [31:0]   rdata_reg;

  // Configuration fields, word length and stop count clamped to the legal ranges
  wire [4:0] wlen_raw = cfg_reg[sctrc_pkg::CFG_WLEN_LSB +: 5];
  wire [1:0] stop_raw = cfg_reg[sctrc_pkg::CFG_STOP_LSB +: 2];
  wire [4:0] wlen = (wlen_raw < 5'(sctrc_pkg::WORD_MIN)) ? 5'(sctrc_pkg::WORD_MIN) :
                    (wlen_raw > 5'(sctrc_pkg::WORD_MAX)) ? 5'(sctrc_pkg::WORD_MAX) :
                    wlen_raw;
  wire [1:0] nstop  = (stop_raw == 2'h0) ? 2'h1 : stop_raw;
  wire       odd    = cfg_reg[sctrc_pkg::CFG_ODD];
  wire       extclk = cfg_reg[sctrc_pkg::CFG_EXTCLK];
  wire       autoirq = cfg_reg[sctrc_pkg::CFG_AUTOIRQ];
  wire [15:0] div   = cfg_reg[sctrc_pkg::CFG_DIV_LSB +: 16];
  wire [23:0] mask  = wmask(wlen);
  wire [5:0] frame_bits = 6'(wlen) + 6'(nstop) + 6'h2;

  // Command decode
  wire sel_data = (addr == sctrc_pkg::OFF_DATA);
  wire sel_cmd  = (addr == sctrc_pkg::OFF_CMD);
  wire out_cmd  = wr_stb && sel_data;
  wire in_cmd   = rd_stb && sel_data;
  wire activate_interrupt_cmd = wr_stb && sel_cmd && wdata[sctrc_pkg::CMD_ACTIVATE];
  wire abort_cmd = wr_stb && sel_cmd && wdata[sctrc_pkg::CMD_ABORT];
  wire cfg_wr   = wr_stb && (addr == sctrc_pkg::OFF_CFG);
  wire jump_no_error_test = rd_stb && (addr == sctrc_pkg::OFF_ERRT);

  // Busy terms and the ready gate
  wire rx_or_tx_active    = busy_receiving_flag || transmitting_flag;
  wire transmit_halt_gate = bit_counter_overflow_flag;
  wire coupler_ready = !post_receive_delay_flag && transmit_halt_gate &&
                       !busy_receiving_flag && !first_bit_flag && dsr_s;
  wire coupler_clear_send = cts_s && request_send_flag;
  // Clear and load are both held off while busy, protecting a word
  wire load_clear_pulse = out_cmd && !rx_or_tx_active;
  wire load_set_pulse   = out_b_reg && !rx_or_tx_active;

  // Transmit bit clock and serializer terms
  logic tx_tick;
  sctrc_bitclk u_txclk (
    .clock     (clock),
    .rst_n     (rst_n),
    .ext_sel   (extclk),
    .div       (div),
    .restart   (1'b0),
    .mclk_sync (mclk_s),
    .tick      (tx_tick)
  );
  wire tx_start = tx_tick && !transmitting_flag && !bit_counter_overflow_flag &&
                  coupler_clear_send && !busy_receiving_flag &&
                  (tx_cnt_reg != 6'h0);
  wire tx_shift = tx_tick && (transmitting_flag || tx_start) && (tx_cnt_reg != 6'h0);
  wire tx_done  = tx_tick && transmitting_flag && (tx_cnt_reg == 6'h0);
  wire par_slot = (tx_cnt_reg == 6'(nstop) + 6'h1);
  wire data_slot = (tx_cnt_reg >= 6'(nstop) + 6'h2) &&
                   (tx_cnt_reg <= 6'(nstop) + 6'h1 + 6'(wlen));
  wire tx_bit = par_slot ? (parity_gen_check_flag ^ odd) : tx_sh_reg[0];
  wire abort_done = abort_run_reg && (abort_cnt_reg == AW'(ABORT_CYCLES - 1));

  // Phase B strobe and the latched word
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      out_b_reg <= 1'b0;
      acc_reg   <= 24'h0;
      cfg_reg   <= sctrc_pkg::CFG_RST;
    end
    else
    begin
      out_b_reg <= out_cmd;
      if (out_cmd)
        acc_reg <= wdata[23:0];
      if (cfg_wr)
        cfg_reg <= wdata;
    end
  end

  // Serializer: parallel load, then shift out LSB first
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_sh_reg             <= '1;
      tx_cnt_reg            <= 6'h0;
      parity_gen_check_flag <= 1'b0;
      line_out_reg          <= 1'b1;
    end
    else if (load_clear_pulse)
    begin
      tx_sh_reg             <= '0;
      tx_cnt_reg            <= 6'h0;
      parity_gen_check_flag <= 1'b0;
    end
    else if (load_set_pulse)
    begin
      // Bits above the word stay one: they become the stop cells
      tx_sh_reg  <= {3'b111, acc_reg | ~mask, 1'b0};
      tx_cnt_reg <= frame_bits;
    end
    else if (tx_shift)
    begin
      line_out_reg <= tx_bit;
      tx_sh_reg    <= {1'b1, tx_sh_reg[FW-1:1]};
      tx_cnt_reg   <= tx_cnt_reg - 6'h1;
      if (data_slot)
        parity_gen_check_flag <= parity_gen_check_flag ^ tx_sh_reg[0];
    end
    else
    begin
      if (tx_done || !transmitting_flag)
        line_out_reg <= 1'b1;
      // Shared flag: a start bit must not spoil the parity of a frame in flight
      if (first_bit_flag && !transmitting_flag)
        parity_gen_check_flag <= 1'b0;
    end
  end

  // Transmit control flags and the abort one-shot
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      transmitting_flag         <= 1'b0;
      bit_counter_overflow_flag <= 1'b1;
      request_send_flag         <= 1'b0;
      abort_run_reg             <= 1'b0;
      abort_cnt_reg             <= '0;
    end
    else
    begin
      if (load_set_pulse)
        bit_counter_overflow_flag <= 1'b0;
      else if (tx_done)
        bit_counter_overflow_flag <= 1'b1;
      if (tx_start)
        transmitting_flag <= 1'b1;
      else if (tx_done)
        transmitting_flag <= 1'b0;
      // A new load wins over an expiring abort
      if (load_set_pulse)
        request_send_flag <= 1'b1;
      else if (abort_done)
        request_send_flag <= 1'b0;
      if (abort_cmd)
        abort_run_reg <= 1'b1;
      else if (abort_done)
        abort_run_reg <= 1'b0;
      abort_cnt_reg <= (abort_cmd || abort_done) ? '0 :
                       abort_run_reg ? abort_cnt_reg + AW'(1) : abort_cnt_reg;
    end
  end

  // Receive bit clock, divider realigned when a start bit is qualified and not refused
  logic rx_tick;
  wire  line_fell = line_prev_reg && !line_s;
  wire  rx_arm    = line_fell && !first_bit_flag && !busy_receiving_flag;
  wire  half_done = first_bit_flag && (half_cnt_reg >= {1'b0, div[15:1]});
  wire  rx_qualify = half_done && !line_s;
  wire  rx_reject  = rx_qualify && (transmitting_flag || in_avail_reg);
  wire  rx_begin   = rx_qualify && !rx_reject;
  wire  rx_done = enable_receive_flag && !rx_sh_reg[0];
  // Data cells plus the parity cell just above the configured word
  wire  [FW-1:0] rx_par_word = rx_sh_reg & {2'h0, 1'b1, ~24'h0, 1'b0} &
                 (28'h3ffffff >> (5'd24 - wlen));
  wire  rx_par_bad = (^rx_par_word) != odd;
  sctrc_bitclk u_rxclk (
    .clock     (clock),
    .rst_n     (rst_n),
    .ext_sel   (extclk),
    .div       (div),
    .restart   (rx_begin),
    .mclk_sync (mclk_s),
    .tick      (rx_tick)
  );

  // Start-bit qualification: space must hold for half a bit time
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      line_prev_reg  <= 1'b1;
      first_bit_flag <= 1'b0;
      half_cnt_reg   <= 16'h0;
    end
    else
    begin
      line_prev_reg <= line_s;
      half_cnt_reg  <= first_bit_flag ? half_cnt_reg + 16'h1 : 16'h0;
      if (rx_arm)
        first_bit_flag <= 1'b1;
      else if (half_done || line_s)
        first_bit_flag <= 1'b0;
    end
  end

  // Deserializer: bits enter at the stop cell, done when start lands
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_sh_reg               <= '1;
      busy_receiving_flag     <= 1'b0;
      enable_receive_flag     <= 1'b0;
      post_receive_delay_flag <= 1'b0;
      in_avail_reg            <= 1'b0;
    end
    else
    begin
      // An unread word must survive a start bit that will be refused
      if (first_bit_flag && !rx_begin && !busy_receiving_flag && !in_avail_reg)
        rx_sh_reg <= '1;
      else if (rx_begin)
        rx_sh_reg <= rx_ins('1, 1'b0, wlen + 5'd2);
      else if (enable_receive_flag && rx_tick)
        rx_sh_reg <= rx_ins(rx_sh_reg, line_s, wlen + 5'd2);
      if (rx_begin)
      begin
        busy_receiving_flag <= 1'b1;
        enable_receive_flag <= 1'b1;
      end
      else if (rx_done)
      begin
        busy_receiving_flag <= 1'b0;
        enable_receive_flag <= 1'b0;
      end
      // One bit of quiet after a word before ready returns
      if (rx_done)
        post_receive_delay_flag <= 1'b1;
      else if (rx_tick)
        post_receive_delay_flag <= 1'b0;
      if (rx_done)
        in_avail_reg <= 1'b1;
      else if (in_cmd)
        in_avail_reg <= 1'b0;
    end
  end

  // Error flag: any set term beats a clear in the same cycle
  wire err_set = rx_reject || (rx_done && rx_par_bad) ||
                 (enable_receive_flag && !dcd_s) ||
                 (rx_or_tx_active && !dsr_s) ||
                 ((out_cmd || in_cmd) && rx_or_tx_active);
  wire err_clr = jump_no_error_test || clear_alarm;

  // Interrupt terms and read data
  wire input_ready_gate  = in_avail_reg && !enable_receive_flag && !busy_receiving_flag;
  wire output_ready_gate = activate_interrupt_cmd && transmit_halt_gate;
  wire out_irq_next = output_ready_gate || (tx_done && out_pend_reg);
  wire in_irq_next  = (rx_done && autoirq) ||
                      (activate_interrupt_cmd && input_ready_gate);
  sctrc_pkg::sctrc_status_s st;
  assign st = '{pad: 22'h0, cts: coupler_clear_send, rts: request_send_flag,
                in_avail: in_avail_reg, enable_rx: enable_receive_flag,
                first_bit: first_bit_flag, busy_rx: busy_receiving_flag,
                txing: transmitting_flag, overflow: bit_counter_overflow_flag,
                error: line_error_flag, ready: coupler_ready};
  wire [31:0] rd_mux = sel_data ? {8'h0, rx_sh_reg[24:1] & mask} :
                       sel_cmd ? st :
                       (addr == sctrc_pkg::OFF_CFG) ? cfg_reg :
                       (addr == sctrc_pkg::OFF_ERRT) ? {31'h0, line_error_flag} : 32'h0;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      line_error_flag <= 1'b0;
      out_pend_reg    <= 1'b0;
      out_irq_reg     <= 1'b0;
      in_irq_reg      <= 1'b0;
      rdata_reg       <= 32'h0;
    end
    else
    begin
      if (err_set)
        line_error_flag <= 1'b1;
      else if (err_clr)
        line_error_flag <= 1'b0;
      if (activate_interrupt_cmd && !transmit_halt_gate)
        out_pend_reg <= 1'b1;
      else if (tx_done)
        out_pend_reg <= 1'b0;
      out_irq_reg <= out_irq_next;
      in_irq_reg  <= in_irq_next;
      rdata_reg   <= rd_stb ? rd_mux : 32'h0;
    end
  end

  assign rdata                  = rdata_reg;
  assign out_irq                = out_irq_reg;
  assign in_irq                 = in_irq_reg;
  assign serial_line_out        = line_out_reg;
  assign modem_request_send_out = request_send_flag;

  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_phase_a_clear: assert property (load_clear_pulse |=> tx_cnt_reg == 6'h0 && !parity_gen_check_flag)
    else $error("phase A did not clear the serializer");
  a_load_word: assert property (load_set_pulse |=> tx_sh_reg[24:1] == ($past(acc_reg) | ~$past(mask)))
    else $error("parallel load mismatch");
  a_load_flags: assert property (load_set_pulse |=> !bit_counter_overflow_flag && request_send_flag && tx_cnt_reg == $past(frame_bits))
    else $error("load did not preset counter and flags");
  a_tx_cause: assert property ($rose(transmitting_flag) |-> $past(coupler_clear_send) && $past(tx_tick))
    else $error("transmit began without clear-to-send or clock");
  a_start_space: assert property ($rose(transmitting_flag) |-> !serial_line_out)
    else $error("frame did not open with a start bit");
  a_tx_halt: assert property ($rose(bit_counter_overflow_flag) |-> !transmitting_flag && serial_line_out)
    else $error("end of shifting left line or flags wrong");
  a_rts_abort: assert property ($fell(request_send_flag) |-> $past(abort_run_reg, 1))
    else $error("request to send dropped without abort delay");
  a_busy_word: assert property (out_cmd && rx_or_tx_active |=> line_error_flag)
    else $error("transfer while busy did not flag an error");
  a_activate_irq: assert property (activate_interrupt_cmd && transmit_halt_gate |=> out_irq)
    else $error("activate while idle gave no output interrupt");
  a_ones_preset: assert property (first_bit_flag && $past(first_bit_flag) &&
                                  !busy_receiving_flag && !in_avail_reg |=>
                                  rx_sh_reg == '1 || enable_receive_flag)
    else $error("first-bit period did not preset ones");
  a_rx_delay: assert property ($fell(busy_receiving_flag) |-> post_receive_delay_flag && !coupler_ready)
    else $error("ready came back without the one-bit delay");
  a_error_hold: assert property (line_error_flag && !err_clr |=> line_error_flag)
    else $error("error flag lost without a clear");

  c_tx_frame: cover property ($rose(transmitting_flag) ##[1:1000] $rose(bit_counter_overflow_flag));
  c_rx_word: cover property ($fell(enable_receive_flag) && !line_error_flag);
  c_rx_reject: cover property (rx_reject);
  c_abort: cover property (abort_done);
endmodule : sctrc_coupler
`default_nettype wire

// *** logic/sctrc_pkg.sv ***
/*
  Shared constants and types of the serial coupler: register offsets,
  field positions, reset values and timing counts.
  Assumes a single 100 MHz system clock for all users.
*/
package sctrc_pkg;
  localparam int CLK_HZ         = 100_000_000;
  localparam int ABORT_DELAY_US = 1000;
  localparam int ABORT_CYC      = ABORT_DELAY_US * (CLK_HZ / 1_000_000);
  localparam int WORD_MAX       = 24;
  localparam int WORD_MIN       = 5;
  localparam int FRAME_W        = 28;
  // Register offsets (byte addresses)
  localparam logic [3:0] OFF_DATA = 4'h0;
  localparam logic [3:0] OFF_CMD  = 4'h4;
  localparam logic [3:0] OFF_CFG  = 4'h8;
  localparam logic [3:0] OFF_ERRT = 4'hc;
  // Command bits
  localparam int CMD_ACTIVATE = 0;
  localparam int CMD_ABORT    = 1;
  // Configuration fields
  localparam int CFG_WLEN_LSB = 0;
  localparam int CFG_STOP_LSB = 5;
  localparam int CFG_ODD      = 7;
  localparam int CFG_EXTCLK   = 8;
  localparam int CFG_AUTOIRQ  = 9;
  localparam int CFG_DIV_LSB  = 16;
  localparam logic [31:0] CFG_RST = 32'h28b0_0028;
  // Status word read at the command offset
  typedef struct packed {
    logic [21:0] pad;
    logic        cts;
    logic        rts;
    logic        in_avail;
    logic        enable_rx;
    logic        first_bit;
    logic        busy_rx;
    logic        txing;
    logic        overflow;
    logic        error;
    logic        ready;
  } sctrc_status_s;
endpackage : sctrc_pkg

// *** logic/sctrc_sync.sv ***
/*
  Two-flop synchroniser for a group of pin inputs.
  Assumes the inputs are asynchronous levels.
*/
`timescale 1ns/1ps
`default_nettype none
module sctrc_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         rst_n,
  // Pins in, synchronised levels out
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;

  // Only the second flop is visible; reset uses ones as idle mark
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_reg <= '1;
      sync_reg <= '1;
    end
    else
    begin
      meta_reg <= pin_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;
endmodule : sctrc_sync
`default_nettype wire

// *** tb/sctrc_modem.sv ***
/*
  Modem model: answers request-to-send with clear-to-send, holds
  data-set-ready and carrier up, and sends frames on request.
  Assumes the bench clock and a bit period of BIT clocks.
*/
`timescale 1ns/1ps
`default_nettype none
module sctrc_modem #(
  parameter int BIT = 8,
  parameter int LAG = 3
) (
  // Clock and handshake
  input  wire logic clock,
  input  wire logic rts,
  // Lines towards the coupler
  output logic      line,
  output logic      cts,
  output logic      dsr,
  output logic      car,
  output logic      mclk
);
  logic [7:0] lag_reg;

  // Idle at mark with the set ready; modem clock unused
  initial
  begin
    line = 1'b1;
    cts = 1'b0;
    dsr = 1'b1;
    car = 1'b1;
    mclk = 1'b0;
    lag_reg = 8'h00;
  end

  // CTS trails RTS a few clocks, both on the way up and down
  always @(posedge clock)
  begin
    lag_reg <= {lag_reg[6:0], rts};
    cts <= lag_reg[LAG-1];
  end

  // Start, data LSB first, parity (flip spoils it), one stop
  task automatic send(input logic [7:0] w, input logic flip);
    logic [10:0] f;
    f = {1'b1, ^w ^ flip, w, 1'b0};
    for (int i = 0; i < 11; i++)
    begin
      @(posedge clock);
      line <= f[i];
      repeat (BIT - 1) @(posedge clock);
    end
  endtask : send
endmodule : sctrc_modem
`default_nettype wire

// *** tb/tb_top.sv ***
/*
  Bench for the serial coupler: register tasks, read-data queue,
  frame sampling and a modem model on the far side.
  Assumes a bit divisor of 8 clocks set through the config register.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        clock;
  logic        rst_n;
  logic [3:0]  addr;
  logic [31:0] wdata;
  logic        wr_stb;
  logic        rd_stb;
  logic        clear_alarm;
  logic [31:0] rdata;
  logic        out_irq, in_irq, line_in, cts, dsr, car, mclk, line_out, rts;
  logic        rd_seen;
  logic [31:0] exp_q[$];
  int          miscompares = 0;
  int          comparisons = 0;
  int          oirq_n = 0;
  int          iirq_n = 0;
  logic [10:0] f;
  logic [7:0]  w;
  logic [7:0]  v;

  sctrc_coupler #(.ABORT_CYCLES(20)) u_sctrc_coupler (.clock(clock), .rst_n(rst_n),
    .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .clear_alarm(clear_alarm), .out_irq(out_irq), .in_irq(in_irq),
    .serial_line_in(line_in), .modem_clear_send_in(cts), .modem_set_ready_in(dsr),
    .modem_carrier_in(car), .modem_clock_in(mclk), .serial_line_out(line_out),
    .modem_request_send_out(rts));
  sctrc_modem #(.BIT(8), .LAG(3)) u_sctrc_modem (.clock(clock), .rts(rts),
    .line(line_in), .cts(cts), .dsr(dsr), .car(car), .mclk(mclk));

  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    comparisons++;
    if (seen !== want)
    begin
      miscompares++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : check

  task automatic wrap_up();
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : wrap_up

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clock);
    wr_stb <= 1'b0;
  endtask : wr

  // Note the expectation now; the watcher compares it a cycle later
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clock);
    addr <= a;
    rd_stb <= 1'b1;
    exp_q.push_back(e);
    @(posedge clock);
    rd_stb <= 1'b0;
  endtask : rd

  // Read data stands only in the cycle after the strobe
  always @(posedge clock)
  begin
    rd_seen <= rd_stb;
    oirq_n <= oirq_n + int'(out_irq);
    iirq_n <= iirq_n + int'(in_irq);
  end
  always @(negedge clock)
    if (rd_seen === 1'b1)
      check(rdata, exp_q.pop_front());

  // Cut a hang short well beyond the under one thousand cycles needed
  initial
  begin
    repeat (8000) @(posedge clock);
    miscompares++;
    wrap_up();
  end

  initial
  begin
    w = 8'($urandom(67153));
    rst_n = 1'b0;
    addr = 4'h0;
    wdata = 32'h0;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    clear_alarm = 1'b0;
    repeat (12) @(posedge clock);
    check({31'h0, line_out}, 32'h1);
    check({31'h0, rts}, 32'h0);
    rst_n <= 1'b1;
    rd(4'h8, sctrc_pkg::CFG_RST);
    wr(4'h8, 32'h0008_0208);
    wr(4'h0, {24'h0, w});
    @(negedge clock);
    @(negedge clock);
    check({31'h0, rts}, 32'h1);
    for (int n = 0; n < 400 && line_out; n++)
      @(negedge clock);
    repeat (4) @(negedge clock);
    for (int i = 0; i < 11; i++)
    begin
      f[i] = line_out;
      repeat (8) @(negedge clock);
    end
    check({21'h0, f}, {21'h0, 1'b1, ^w, w, 1'b0});
    rd(4'h4, 32'h0000_0305);
    wr(4'h4, 32'h1);
    repeat (3) @(negedge clock);
    check(32'(oirq_n), 32'h1);
    wr(4'h4, 32'h2);
    repeat (5) @(negedge clock);
    check({31'h0, rts}, 32'h1);
    repeat (30) @(negedge clock);
    check({31'h0, rts}, 32'h0);
    $display("transmit test done");
    wr(4'h0, 32'h5a);
    for (int n = 0; n < 400 && line_out; n++)
      @(negedge clock);
    wr(4'h0, 32'ha5);
    rd(4'hc, 32'h1);
    wr(4'h4, 32'h1);
    repeat (120) @(negedge clock);
    check(32'(oirq_n), 32'h2);
    $display("busy test done");
    w = 8'($urandom());
    u_sctrc_modem.send(w, 1'b0);
    repeat (16) @(posedge clock);
    rd(4'h0, {24'h0, w});
    rd(4'hc, 32'h0);
    check(32'(iirq_n), 32'h1);
    v = 8'($urandom());
    u_sctrc_modem.send(v, 1'b0);
    u_sctrc_modem.send(~v, 1'b0);
    repeat (16) @(posedge clock);
    rd(4'h0, {24'h0, v});
    rd(4'hc, 32'h1);
    rd(4'hc, 32'h0);
    u_sctrc_modem.send(w, 1'b1);
    repeat (16) @(posedge clock);
    rd(4'hc, 32'h1);
    rd(4'h0, {24'h0, w});
    wr(4'h8, 32'h0008_0288);
    w = 8'($urandom());
    u_sctrc_modem.send(w, 1'b1);
    repeat (16) @(posedge clock);
    rd(4'hc, 32'h0);
    rd(4'h0, {24'h0, w});
    $display("receive test done");
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
